// [ldbdc_map.svh]
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz block clock, 32-bit APB register words
// Notes:   per-mille levels, 1000 = full-scale LED current
`ifndef LDBDC_MAP_SVH
`define LDBDC_MAP_SVH

// ********************************
// register offsets
// ********************************
`define LDBDC_OFS_CTRL      12'h000
`define LDBDC_OFS_STATUS    12'h004
`define LDBDC_OFS_PRESENT   12'h008
`define LDBDC_OFS_LEVEL     12'h00C

// ********************************
// field positions and reset values
// ********************************
`define LDBDC_CTRL_EN_BIT   0
`define LDBDC_CTRL_RST      32'h0000_0001
`define LDBDC_ST_SHDN_BIT   4
`define LDBDC_ST_TEST_BIT   5
`define LDBDC_ST_OVPL_BIT   6
`define LDBDC_ST_LS_BIT     7
`define LDBDC_LV_MODE_LSB   16

// ********************************
// timing
// ********************************
`define LDBDC_CLK_KHZ       100000
`define LDBDC_OSC_KHZ       1000
`define LDBDC_OSC_CYC       (`LDBDC_CLK_KHZ / `LDBDC_OSC_KHZ)
`define LDBDC_DET_NS        2000
`define LDBDC_DET_CYC       ((`LDBDC_DET_NS * (`LDBDC_CLK_KHZ / 1000) + 999) / 1000)
`define LDBDC_ACT_US        200
`define LDBDC_ACT_CYC       (`LDBDC_ACT_US * (`LDBDC_CLK_KHZ / 1000))

// ********************************
// brightness levels, per mille
// ********************************
`define LDBDC_PM_FULL       10'h3E8
`define LDBDC_PM_MIN        10'h096
`define LDBDC_PM_SHDN_DUTY  10'h032
`define LDBDC_PM3_1         10'h08F
`define LDBDC_PM3_2         10'h10A
`define LDBDC_PM3_3         10'h1AD
`define LDBDC_PM3_4         10'h23B
`define LDBDC_PM3_5         10'h2CA
`define LDBDC_PM3_6         10'h359
`define LDBDC_PM2_1         10'h14D
`define LDBDC_PM2_2         10'h29B

`endif

// [ldbdc_pkg.sv]
// Purpose: types shared by the LED boost and dimming control
// Assumes: nothing beyond the map header
// Notes:   none
package ldbdc_pkg;

    // ********************************
    // sequencer states and dimming modes
    // ********************************
    typedef enum logic [2:0] {
        ST_OFF,
        ST_RAMP,
        ST_DETECT,
        ST_WAIT,
        ST_RUN,
        ST_TEST
    } ldbdc_state_t;

    typedef enum logic [2:0] {
        DM_PAR3,
        DM_PAR2,
        DM_DUTY,
        DM_ANALOG
    } ldbdc_dmode_t;

    // ********************************
    // bundled signals
    // ********************************
    typedef struct packed {
        logic mode;
        logic dim_a;
        logic dim_b;
        logic dim_c;
        logic sel_hi;
        logic sel_lo;
        logic full_scale_current_set_gnd;
    } ldbdc_strap_t;

    typedef struct packed {
        logic ls_on;
        logic rect_on;
    } ldbdc_gate_t;

endpackage

// [ldbdc_top.sv]
// Purpose: boost switch control, LED presence start-up, dimming decode
// Assumes: analog front end supplies comparator flags and per-mille codes
// Notes:   APB slave with zero wait states and registered answers
//
// What this block does
// - ramp output to overvoltage level, stop switching, then test channels
// - channel under detection threshold at test is absent, left out of feedback
// - channel above detection threshold, even shorted high, counts as LED
// - after the test, switching restarts when weakest active drop hits threshold
// - feedback is the minimum drop over active channels against reference
// - oscillator rise starts on-time only if comparator, overcurrent, OV low
// - on-time ends on comparator high, overcurrent or oscillator fall
// - overvoltage turns both switches off until low, comparator low, next rise
// - regulator starts after lockout clears and reference ready, unless shut down
// - mode high, first input duty sets current at either third input level
// - duty mode shuts down below five percent duty while third input low
// - mode, first, third high, second input level sets brightness
// - analog mode shuts down when first and second inputs both low
// - mode low decodes 3-bit code, first input MSB, third LSB
// - mode high, third low decodes 2-bit code, first MSB, second LSB
// - parallel modes shut down when all inputs low, wake on any high
// - 3-bit codes 1 to 7 map to seven rising brightness steps
// - 2-bit codes 1 to 3 map to third, two thirds and full current
// - subset input is three-level, each level enabling its own group
// - high enables all, low lower group, middle upper group
// - grounded setting pin gives test mode, no switching, inputs ignored
// - continuous dimming stays between minimum fraction and full scale
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "ldbdc_map.svh"

module ldbdc_top #(
    parameter int NCH     = 8,
    parameter int LOW_GRP = 5,
    parameter int ACT_CYC = `LDBDC_ACT_CYC
) (
    // clock and reset
    input  wire logic            CLK_I,
    input  wire logic            RST_I,
    // apb slave
    input  wire logic            PSEL_I,
    input  wire logic            PENABLE_I,
    input  wire logic            PWRITE_I,
    input  wire logic [11:0]     PADDR_I,
    input  wire logic [31:0]     PWDATA_I,
    output logic      [31:0]     PRDATA_O,
    output logic                 PREADY_O,
    output logic                 PSLVERR_O,
    // supply and analog flags
    input  wire logic            UNDERVOLTAGE_LOCKOUT_OK_I,
    input  wire logic            REF_RDY_I,
    input  wire logic            OVP_HI_I,
    input  wire logic            OVP_BELOW_FALL_I,
    input  wire logic            SUM_CMP_I,
    input  wire logic            OVERCUR_I,
    input  wire logic [NCH-1:0]  CH_PRESENT_I,
    input  wire logic [NCH-1:0]  CH_REG_LOW_I,
    // dimming and strap pins
    input  wire logic            MODE_I,
    input  wire logic            DIM_A_I,
    input  wire logic            DIM_B_I,
    input  wire logic            DIM_C_I,
    input  wire logic            SEL_HI_I,
    input  wire logic            SEL_LO_I,
    input  wire logic            FULL_SCALE_CURRENT_SET_GND_I,
    input  wire logic [9:0]      DUTY_PM_I,
    input  wire logic [9:0]      LEVEL_PM_I,
    // switch and sink control
    output logic                 LS_GATE_O,
    output logic                 RECT_GATE_O,
    output logic [NCH-1:0]       SINK_EN_O,
    output logic [NCH-1:0]       FB_MASK_O,
    output logic [9:0]           BRIGHT_PM_O,
    output logic                 TEST_MODE_O,
    output logic                 SHDN_O
);

    localparam int OSC_CYC = `LDBDC_OSC_CYC;
    localparam int DET_CYC = `LDBDC_DET_CYC;
    localparam int OW      = $clog2(OSC_CYC);
    localparam int DW      = $clog2(DET_CYC + 1);
    localparam int AW      = $clog2(ACT_CYC + 1);
    localparam logic [OW-1:0] OSC_LAST = OW'(OSC_CYC - 1);
    localparam logic [OW-1:0] OSC_HALF = OW'(OSC_CYC / 2);
    localparam logic [DW-1:0] DET_LAST = DW'(DET_CYC);
    localparam logic [AW-1:0] ACT_LAST = AW'(ACT_CYC);
    localparam logic [31:0]   CTRL_RST = `LDBDC_CTRL_RST;

    // ********************************
    // strap synchroniser
    // ********************************
    ldbdc_pkg::ldbdc_strap_t strap_in;
    ldbdc_pkg::ldbdc_strap_t strap_m_r;
    ldbdc_pkg::ldbdc_strap_t strap_r;
    logic                    dim_a_d_r;

    assign strap_in = '{MODE_I, DIM_A_I, DIM_B_I, DIM_C_I,
                        SEL_HI_I, SEL_LO_I, FULL_SCALE_CURRENT_SET_GND_I};

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            strap_m_r <= '0;
            strap_r   <= '0;
            dim_a_d_r <= 1'b0;
        end else begin
            strap_m_r <= strap_in;
            strap_r   <= strap_m_r;
            dim_a_d_r <= strap_r.dim_a;
        end
    end

    // ********************************
    // oscillator divider
    // ********************************
    logic [OW-1:0] osc_cnt_r;
    wire           osc_rise = (osc_cnt_r == '0);
    wire           osc_fall = (osc_cnt_r == OSC_HALF);

    always_ff @(posedge CLK_I) begin
        if (RST_I || osc_cnt_r == OSC_LAST)
            osc_cnt_r <= '0;
        else
            osc_cnt_r <= osc_cnt_r + 1'b1;
    end

    // ********************************
    // first dimming input activity
    // ********************************
    logic [AW-1:0] act_cnt_r;
    wire           a_edge   = strap_r.dim_a ^ dim_a_d_r;
    wire           a_active = (act_cnt_r != ACT_LAST);

    always_ff @(posedge CLK_I) begin
        if (RST_I)
            act_cnt_r <= ACT_LAST;
        else if (a_edge)
            act_cnt_r <= '0;
        else if (a_active)
            act_cnt_r <= act_cnt_r + 1'b1;
    end

    // ********************************
    // dimming decode
    // ********************************
    wire [2:0] code3 = {strap_r.dim_a, strap_r.dim_b, strap_r.dim_c};
    wire [1:0] code2 = {strap_r.dim_a, strap_r.dim_b};
    ldbdc_pkg::ldbdc_dmode_t dmode;
    logic [9:0] lvl3;
    logic [9:0] lvl2;
    logic [9:0] lvl_cont;
    logic [9:0] lvl_sel;
    logic       dim_shdn;

    assign dmode = !strap_r.mode ? ldbdc_pkg::DM_PAR3 :
                   a_active      ? ldbdc_pkg::DM_DUTY :
                   strap_r.dim_c ? ldbdc_pkg::DM_ANALOG :
                                   ldbdc_pkg::DM_PAR2;

    always_comb begin
        case (code3)
            3'h1:    lvl3 = `LDBDC_PM3_1;
            3'h2:    lvl3 = `LDBDC_PM3_2;
            3'h3:    lvl3 = `LDBDC_PM3_3;
            3'h4:    lvl3 = `LDBDC_PM3_4;
            3'h5:    lvl3 = `LDBDC_PM3_5;
            3'h6:    lvl3 = `LDBDC_PM3_6;
            3'h7:    lvl3 = `LDBDC_PM_FULL;
            default: lvl3 = 10'h000;
        endcase
        case (code2)
            2'h1:    lvl2 = `LDBDC_PM2_1;
            2'h2:    lvl2 = `LDBDC_PM2_2;
            2'h3:    lvl2 = `LDBDC_PM_FULL;
            default: lvl2 = 10'h000;
        endcase
    end

    wire [9:0] cont_raw = (dmode == ldbdc_pkg::DM_DUTY) ? DUTY_PM_I
                                                        : LEVEL_PM_I;
    // continuous modes clamp into the supported band
    assign lvl_cont = (cont_raw < `LDBDC_PM_MIN)  ? `LDBDC_PM_MIN :
                      (cont_raw > `LDBDC_PM_FULL) ? `LDBDC_PM_FULL :
                                                    cont_raw;

    assign lvl_sel = (dmode == ldbdc_pkg::DM_PAR3) ? lvl3 :
                     (dmode == ldbdc_pkg::DM_PAR2) ? lvl2 : lvl_cont;

    always_comb begin
        case (dmode)
            ldbdc_pkg::DM_PAR3,
            ldbdc_pkg::DM_PAR2:
                dim_shdn = (code3 == 3'h0);
            ldbdc_pkg::DM_DUTY:
                dim_shdn = (DUTY_PM_I < `LDBDC_PM_SHDN_DUTY)
                           && !strap_r.dim_c;
            ldbdc_pkg::DM_ANALOG:
                dim_shdn = !strap_r.dim_a && !strap_r.dim_b;
            default:
                dim_shdn = 1'b1;
        endcase
    end

    // ********************************
    // channel subset select
    // ********************************
    logic [NCH-1:0] sel_mask;

    generate
        for (genvar i = 0; i < NCH; i++) begin : g_sel
            // high: all, low: lower group, middle: upper group
            assign sel_mask[i] = strap_r.sel_hi ||
                                 (strap_r.sel_lo ? (i < LOW_GRP)
                                                 : (i >= LOW_GRP));
        end
    endgenerate

    // ********************************
    // control register
    // ********************************
    logic           ctrl_en_r;
    logic [NCH-1:0] present_r;

    // ********************************
    // start-up sequencer
    // ********************************
    ldbdc_pkg::ldbdc_state_t state_r;
    ldbdc_pkg::ldbdc_state_t state_nxt;
    logic [DW-1:0] det_cnt_r;
    wire           det_done = (det_cnt_r == DET_LAST);
    wire           test_req = strap_r.full_scale_current_set_gnd;
    wire           go_ok    = UNDERVOLTAGE_LOCKOUT_OK_I && REF_RDY_I && ctrl_en_r
                              && !dim_shdn;
    wire           fb_low   = |(CH_REG_LOW_I & present_r);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ldbdc_pkg::ST_OFF:
                if (test_req)
                    state_nxt = ldbdc_pkg::ST_TEST;
                else if (go_ok)
                    state_nxt = ldbdc_pkg::ST_RAMP;
            ldbdc_pkg::ST_RAMP:
                if (OVP_HI_I)
                    state_nxt = ldbdc_pkg::ST_DETECT;
            ldbdc_pkg::ST_DETECT:
                if (det_done)
                    state_nxt = ldbdc_pkg::ST_WAIT;
            ldbdc_pkg::ST_WAIT:
                if (fb_low)
                    state_nxt = ldbdc_pkg::ST_RUN;
            ldbdc_pkg::ST_RUN:
                state_nxt = state_r;
            ldbdc_pkg::ST_TEST:
                if (!test_req)
                    state_nxt = ldbdc_pkg::ST_OFF;
            default:
                state_nxt = ldbdc_pkg::ST_OFF;
        endcase
        if (state_r != ldbdc_pkg::ST_TEST && state_r != ldbdc_pkg::ST_OFF
            && (test_req || !go_ok))
            state_nxt = ldbdc_pkg::ST_OFF;
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I)
            state_r <= ldbdc_pkg::ST_OFF;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I || state_r != ldbdc_pkg::ST_DETECT)
            det_cnt_r <= '0;
        else if (!det_done)
            det_cnt_r <= det_cnt_r + 1'b1;
    end

    // presence: above threshold, shorted high included, counts as LED
    always_ff @(posedge CLK_I) begin
        if (RST_I || state_r == ldbdc_pkg::ST_OFF)
            present_r <= '0;
        else if (state_r == ldbdc_pkg::ST_DETECT && det_done)
            present_r <= CH_PRESENT_I & sel_mask;
    end

    // ********************************
    // switch cycle control
    // ********************************
    logic ovp_lock_r;
    logic ovp_lock_nxt;
    ldbdc_pkg::ldbdc_gate_t gate_r;
    ldbdc_pkg::ldbdc_gate_t gate_nxt;
    wire  sw_allowed = (state_r == ldbdc_pkg::ST_RAMP)
                       || (state_r == ldbdc_pkg::ST_RUN);
    wire  lock_clear = osc_rise && OVP_BELOW_FALL_I && !SUM_CMP_I;
    wire  start_ok   = osc_rise && !SUM_CMP_I && !OVERCUR_I && !OVP_HI_I;
    wire  end_on     = SUM_CMP_I || OVERCUR_I || osc_fall;

    assign ovp_lock_nxt = OVP_HI_I ? 1'b1 :
                          lock_clear ? 1'b0 : ovp_lock_r;

    always_comb begin
        gate_nxt = gate_r;
        if (!sw_allowed || OVP_HI_I || (ovp_lock_r && !lock_clear)) begin
            gate_nxt = '0;
        end else if (start_ok) begin
            gate_nxt = '{ls_on: 1'b1, rect_on: 1'b0};
        end else if (gate_r.ls_on && end_on) begin
            gate_nxt = '{ls_on: 1'b0, rect_on: 1'b1};
        end else if (!gate_r.ls_on) begin
            gate_nxt.rect_on = 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            gate_r     <= '0;
            ovp_lock_r <= 1'b0;
        end else begin
            gate_r     <= gate_nxt;
            ovp_lock_r <= ovp_lock_nxt;
        end
    end

    // ********************************
    // sink, feedback and level outputs
    // ********************************
    logic [NCH-1:0] sink_r;
    logic [NCH-1:0] fb_r;
    logic [9:0]     bright_r;
    logic           test_r;
    logic           shdn_r;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            sink_r   <= '0;
            fb_r     <= '0;
            bright_r <= 10'h000;
            test_r   <= 1'b0;
            shdn_r   <= 1'b1;
        end else begin
            case (state_r)
                ldbdc_pkg::ST_DETECT,
                ldbdc_pkg::ST_TEST: sink_r <= sel_mask;
                ldbdc_pkg::ST_WAIT,
                ldbdc_pkg::ST_RUN:  sink_r <= present_r;
                default:            sink_r <= '0;
            endcase
            fb_r     <= present_r;
            test_r   <= (state_r == ldbdc_pkg::ST_TEST);
            shdn_r   <= dim_shdn && !test_req;
            bright_r <= test_req ? 10'h000 : lvl_sel;
        end
    end

    // ********************************
    // apb slave
    // ********************************
    wire        setup  = PSEL_I && !PENABLE_I;
    wire        wr_acc = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    wire        hit_ctrl = (PADDR_I == `LDBDC_OFS_CTRL);
    wire        hit_any  = hit_ctrl || (PADDR_I == `LDBDC_OFS_STATUS)
                           || (PADDR_I == `LDBDC_OFS_PRESENT)
                           || (PADDR_I == `LDBDC_OFS_LEVEL);
    wire [31:0] st_word = {24'h0, gate_r.ls_on, ovp_lock_r, test_r,
                           shdn_r, 1'b0, 3'(state_r)};
    wire [31:0] lv_word = {13'h0, 3'(dmode), 6'h0, bright_r};
    wire [31:0] rd_mux  =
        hit_ctrl                          ? {31'h0, ctrl_en_r} :
        (PADDR_I == `LDBDC_OFS_STATUS)    ? st_word :
        (PADDR_I == `LDBDC_OFS_PRESENT)   ? 32'(present_r) :
        (PADDR_I == `LDBDC_OFS_LEVEL)     ? lv_word : 32'h0000_0000;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
            ctrl_en_r <= CTRL_RST[`LDBDC_CTRL_EN_BIT];
        end else begin
            PREADY_O  <= setup;
            PSLVERR_O <= setup && !hit_any;
            if (setup && !PWRITE_I)
                PRDATA_O <= rd_mux;
            if (wr_acc && hit_ctrl)
                ctrl_en_r <= PWDATA_I[`LDBDC_CTRL_EN_BIT];
        end
    end

    assign LS_GATE_O   = gate_r.ls_on;
    assign RECT_GATE_O = gate_r.rect_on;
    assign SINK_EN_O   = sink_r;
    assign FB_MASK_O   = fb_r;
    assign BRIGHT_PM_O = bright_r;
    assign TEST_MODE_O = test_r;
    assign SHDN_O      = shdn_r;

    // ********************************
    // checks
    // ********************************
    sequence s_det_end;
        state_r == ldbdc_pkg::ST_DETECT && det_done;
    endsequence

    sequence s_test_held;
        test_req ##1 test_req;
    endsequence

    chk_start_cycle: assert property (@(posedge CLK_I) disable iff (RST_I)
        (sw_allowed && !ovp_lock_r && start_ok) |=> gate_r.ls_on)
        else $error("switch did not start at oscillator rise");

    chk_end_ontime: assert property (@(posedge CLK_I) disable iff (RST_I)
        (gate_r.ls_on && (SUM_CMP_I || OVERCUR_I))
        |=> !gate_r.ls_on && (gate_r.rect_on || $past(OVP_HI_I)
                              || $past(ovp_lock_r) || !$past(sw_allowed)))
        else $error("on-time not ended");

    chk_ovp_both_off: assert property (@(posedge CLK_I) disable iff (RST_I)
        OVP_HI_I |=> !gate_r.ls_on && !gate_r.rect_on
                     && ovp_lock_r)
        else $error("switches on during overvoltage");

    chk_presence_mask: assert property (@(posedge CLK_I) disable iff (RST_I)
        s_det_end |=> present_r == ($past(CH_PRESENT_I) & $past(sel_mask)))
        else $error("presence mask wrong");

    chk_restart_wait: assert property (@(posedge CLK_I) disable iff (RST_I)
        (state_r == ldbdc_pkg::ST_WAIT && fb_low && go_ok && !test_req)
        |=> state_r == ldbdc_pkg::ST_RUN)
        else $error("switching did not restart");

    chk_ramp_sinks: assert property (@(posedge CLK_I) disable iff (RST_I)
        (state_r == ldbdc_pkg::ST_RAMP) ##1 (state_r == ldbdc_pkg::ST_RAMP)
        |-> sink_r == '0)
        else $error("sink enabled during ramp");

    chk_test_inhibit: assert property (@(posedge CLK_I) disable iff (RST_I)
        s_test_held |=> !gate_r.ls_on && bright_r == 10'h000)
        else $error("switching in test mode");

    chk_par3_full: assert property (@(posedge CLK_I) disable iff (RST_I)
        (!strap_r.mode && code3 == 3'h7 && !test_req)
        |=> bright_r == `LDBDC_PM_FULL)
        else $error("3-bit full code wrong");

    chk_par_shdn: assert property (@(posedge CLK_I) disable iff (RST_I)
        (dmode == ldbdc_pkg::DM_PAR2 && code3 == 3'h0 && !test_req)
        |=> shdn_r)
        else $error("parallel shutdown missed");

    chk_cont_range: assert property (@(posedge CLK_I) disable iff (RST_I)
        (dmode == ldbdc_pkg::DM_ANALOG && !test_req)
        |=> bright_r >= `LDBDC_PM_MIN && bright_r <= `LDBDC_PM_FULL)
        else $error("analog level out of range");

endmodule

// [ldbdc_host.sv]
// Purpose: host model driving the dimming, select and set pins
// Assumes: pins move only just after a rising edge
// Notes:   select never shows high and low at once
`timescale 1ns/1ps
module ldbdc_host (
    // clock
    input  wire logic                    clk_i,
    // wanted pin levels
    input  wire ldbdc_pkg::ldbdc_strap_t req_i,
    // duty wave high time in cycles, zero for none
    input  wire logic [7:0]              pwm_hi_i,
    // pins
    output ldbdc_pkg::ldbdc_strap_t      pins_o
);
    logic [7:0]              ph_r = 8'h00;
    ldbdc_pkg::ldbdc_strap_t pins_nxt;

    // neither select level means the middle level
    always_comb begin
        pins_nxt        = req_i;
        pins_nxt.sel_lo = req_i.sel_lo & ~req_i.sel_hi;
        // 200-cycle period, 500 kHz, inside the supported band
        if (pwm_hi_i != 8'h00)
            pins_nxt.dim_a = (ph_r < pwm_hi_i);
    end

    always @(posedge clk_i) begin
        ph_r   <= (ph_r == 8'hC7) ? 8'h00 : ph_r + 8'h01;
        pins_o <= pins_nxt;
    end
endmodule

// [ldbdc_top_tb.sv]
// Purpose: self-checking bench for the LED boost and dimming control
// Assumes: APB answers within a few cycles, shortened idle window
// Notes:   decode settles within eight cycles of a pin change, within 320 after a first-input edge in mode high
`timescale 1ns/1ps
`include "ldbdc_map.svh"
module ldbdc_top_tb;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, e, ls, rect, tmode, shdn;
    logic undervoltage_lockout = 1'b0, refr = 1'b0, ovph = 1'b0, cmp = 1'b0;
    logic [7:0] reglow = 8'h00, sink, fb, pwm = 8'h00;
    logic [9:0] bright, lvl = 10'h000, duty = 10'h000;
    ldbdc_pkg::ldbdc_strap_t req = '0, pins;
    int miscompares = 0, check_count = 0, n;
    logic [9:0] t3 [8] = '{10'h000, `LDBDC_PM3_1, `LDBDC_PM3_2,
        `LDBDC_PM3_3, `LDBDC_PM3_4, `LDBDC_PM3_5, `LDBDC_PM3_6,
        `LDBDC_PM_FULL};
    logic [9:0] t2 [4] = '{10'h000, `LDBDC_PM2_1, `LDBDC_PM2_2,
        `LDBDC_PM_FULL};
    logic [7:0] msk [3] = '{8'hFF, 8'h1F, 8'hE0};
    always #5 clk = ~clk;
    ldbdc_host host (.clk_i(clk), .req_i(req), .pwm_hi_i(pwm),
        .pins_o(pins));
    ldbdc_top #(.ACT_CYC(300)) dut (.CLK_I(clk), .RST_I(rst),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .UNDERVOLTAGE_LOCKOUT_OK_I(undervoltage_lockout), .REF_RDY_I(refr),
        .OVP_HI_I(ovph), .OVP_BELOW_FALL_I(1'b1), .SUM_CMP_I(cmp),
        .OVERCUR_I(1'b0), .CH_PRESENT_I(8'hA5), .CH_REG_LOW_I(reglow),
        .MODE_I(pins.mode), .DIM_A_I(pins.dim_a), .DIM_B_I(pins.dim_b),
        .DIM_C_I(pins.dim_c), .SEL_HI_I(pins.sel_hi),
        .SEL_LO_I(pins.sel_lo), .FULL_SCALE_CURRENT_SET_GND_I(pins.full_scale_current_set_gnd),
        .DUTY_PM_I(duty), .LEVEL_PM_I(lvl), .LS_GATE_O(ls),
        .RECT_GATE_O(rect), .SINK_EN_O(sink), .FB_MASK_O(fb),
        .BRIGHT_PM_O(bright), .TEST_MODE_O(tmode), .SHDN_O(shdn));
    task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
        check_count++;
        if (g !== x) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_ls();
        n = 0;
        while (ls !== 1'b1 && n < 300) begin @(posedge clk); n++; end
        chk("ls_on", 1, ls);
        chk("rect_off", 0, rect);
    endtask
    task automatic wrap_up();
        if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
    // ****************
    // tests
    // ****************
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("shdn_rst", 1, shdn);
        apb(0, `LDBDC_OFS_CTRL, 0);
        chk("ctrl_rst", `LDBDC_CTRL_RST, rd);
        apb(1, 12'h010, 32'hFFFFFFFF);
        chk("slverr", 1, e);
        apb(0, 12'h010, 0);
        chk("unmapped", 0, rd);
        for (int i = 0; i < 8; i++) begin
            {req.dim_a, req.dim_b, req.dim_c} <= i[2:0];
            repeat (8) @(posedge clk);
            chk("lvl3", t3[i], bright);
            chk("shdn3", i == 0, shdn);
        end
        for (int i = 0; i < 4; i++) begin
            req.mode <= 1'b1;
            {req.dim_a, req.dim_b, req.dim_c} <= {i[1:0], 1'b0};
            repeat (320) @(posedge clk);
            chk("lvl2", t2[i], bright);
            chk("shdn2", i == 0, shdn);
        end
        {req.dim_a, req.dim_c} <= 2'b11;
        lvl <= 10'h064;
        repeat (320) @(posedge clk);
        chk("ana_min", `LDBDC_PM_MIN, bright);
        lvl <= 10'h258;
        repeat (8) @(posedge clk);
        chk("ana_lvl", 10'h258, bright);
        {req.dim_a, req.dim_b} <= 2'b00;
        repeat (320) @(posedge clk);
        chk("ana_shdn", 1, shdn);
        pwm <= 8'h78;
        duty <= 10'h258;
        repeat (100) @(posedge clk);
        chk("duty_lvl", 10'h258, bright);
        chk("duty_on", 0, shdn);
        req.dim_c <= 1'b0;
        pwm <= 8'h06;
        duty <= 10'h01E;
        repeat (8) @(posedge clk);
        chk("duty_shdn", 1, shdn);
        pwm <= 8'h00;
        {undervoltage_lockout, refr, req.full_scale_current_set_gnd} <= 3'b111;
        for (int i = 0; i < 3; i++) begin
            {req.sel_hi, req.sel_lo} <= (i == 0) ? 2'b10 : {1'b0, i == 1};
            repeat (8) @(posedge clk);
            chk("test", 1, tmode);
            chk("test_lvl", 0, bright);
            chk("test_sw", 0, ls);
            chk("subset", msk[i], sink);
        end
        req <= '{mode: 1'b0, dim_c: 1'b1, sel_hi: 1'b1, default: 1'b0};
        wait_ls();
        cmp <= 1'b1;
        repeat (3) @(posedge clk);
        chk("cmp_off", 0, ls);
        ovph <= 1'b1;
        repeat (4) @(posedge clk);
        chk("ovp_off", 0, ls | rect);
        chk("det_sink", 8'hFF, sink);
        ovph <= 1'b0;
        cmp <= 1'b0;
        repeat (210) @(posedge clk);
        chk("fb", 8'hA5, fb);
        reglow <= 8'h04;
        wait_ls();
        apb(0, `LDBDC_OFS_STATUS, 0);
        chk("run", 3'h4, rd[2:0]);
        wrap_up();
    end
endmodule
